/* File: hdl/adc_ctrl_map.svh */
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// ----------------------------------------
// single-byte opcodes
// ----------------------------------------
`define OP_WAKE        8'h02
`define OP_STANDBY     8'h04
`define OP_RESET       8'h06
`define OP_START       8'h08
`define OP_STOP        8'h0A
`define OP_OFFSET      8'h1A
`define OP_STREAM_ON   8'h10
`define OP_STREAM_OFF  8'h11
`define OP_READ_ONCE   8'h12

// ----------------------------------------
// multi-byte opcode fields
// ----------------------------------------
`define OP_FETCH_HI    3'h1
`define OP_STORE_HI    3'h2
`define OP_COUNT_HI    3'h0

// ----------------------------------------
// serial edge counts
// ----------------------------------------
`define BIT_SYS        4'h7
`define BIT_REG        4'h8

// ----------------------------------------
// timing, in master clocks and modulator periods
// ----------------------------------------
`define MOD_LAST_DIV0  5'h03
`define MOD_LAST_DIV1  5'h0F
`define SETTLE_R0      13'h1004
`define SETTLE_R1      13'h0804
`define SETTLE_R2      13'h0404
`define SETTLE_R3      13'h0204
`define SETTLE_R4      13'h0104
`define SETTLE_R5      13'h0084
`define SETTLE_R6      13'h0044
`define SETTLE_R7      13'h0024
`define SETTLE_MIN     13'h0024
`define SETTLE_FIXED   13'h0004
`define FILL_SHIFT     2

`endif

/* File: hdl/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

  typedef enum logic [1:0] {CONV_IDLE, CONV_SETTLE, CONV_RUN, CONV_HOLD} conv_state_type;

  typedef enum logic {CMD_FIRST, CMD_SECOND} cmd_state_type;

  // one received serial edge, already in the system clock domain
  typedef struct packed {
    logic       fall;
    logic [3:0] bits;
    logic [7:0] shift;
    logic       cs_high;
  } rx_event_type;

  // single-cycle system command pulses
  typedef struct packed {
    logic wake;
    logic standby;
    logic reset;
    logic offset;
    logic read_once;
  } sys_cmd_type;

  // decoded register access
  typedef struct packed {
    logic       store;
    logic [4:0] addr;
    logic [4:0] count;
  } reg_cmd_type;

endpackage : adc_ctrl_pkg

/* File: hdl/serial_byte_rx.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_map.svh"

module serial_byte_rx
  import adc_ctrl_pkg::*;
(
  input  wire logic   clk_sys_i,
  input  wire logic   rst_n_i,
  input  wire logic   cs_n_i,
  input  wire logic   sclk_i,
  input  wire logic   din_i,
  output rx_event_type evt_o
);

  logic [1:0]   cs_sync_reg, cs_sync_next;
  logic [1:0]   sclk_sync_reg, sclk_sync_next;
  logic [1:0]   din_sync_reg, din_sync_next;
  logic         sclk_d_reg, sclk_d_next;
  rx_event_type evt_reg, evt_next;

  // ----------------------------------------
  // synchronise pins, count falling edges
  // ----------------------------------------
  always_comb begin
    cs_sync_next   = {cs_sync_reg[0], cs_n_i};
    sclk_sync_next = {sclk_sync_reg[0], sclk_i};
    din_sync_next  = {din_sync_reg[0], din_i};
    sclk_d_next    = sclk_sync_reg[1];
    evt_next       = evt_reg;
    evt_next.fall  = 1'b0;
    evt_next.cs_high = cs_sync_reg[1];
    if (cs_sync_reg[1]) begin
      evt_next.bits = 4'h0;   // frame boundary restarts the byte
    end else if (sclk_d_reg && !sclk_sync_reg[1]) begin
      evt_next.fall  = 1'b1;
      evt_next.shift = {evt_reg.shift[6:0], din_sync_reg[1]};
      evt_next.bits  = (evt_reg.bits == `BIT_REG) ? 4'h1 : evt_reg.bits + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cs_sync_reg   <= 2'h3;
      sclk_sync_reg <= 2'h0;
      din_sync_reg  <= 2'h0;
      sclk_d_reg    <= 1'b0;
      evt_reg       <= '{fall: 1'b0, bits: 4'h0, shift: 8'h00, cs_high: 1'b1};
    end else begin
      cs_sync_reg   <= cs_sync_next;
      sclk_sync_reg <= sclk_sync_next;
      din_sync_reg  <= din_sync_next;
      sclk_d_reg    <= sclk_d_next;
      evt_reg       <= evt_next;
    end
  end

  assign evt_o = evt_reg;

endmodule : serial_byte_rx

`default_nettype wire

/* File: hdl/adc_conversion_and_opcode_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_map.svh"

// Notes on behaviour
// - start raises data-ready; low when data settled
// - first data after rate-coded settle time
// - running period is quarter of settle span less the fixed part
// - continuous runs while pin high or start flag set; stop clears flag
// - start and stop act at seventh edge
// - conversion in progress completes after halting
// - one-shot mode converts once per start
// - one-shot keeps data-ready low afterwards
// - each accepted start resets the digital filter
// - fixed start-to-ready delay for synchronising devices
// - serial output released while select high
// - system ops at seventh, register ops eighth
// - decode wake, standby, reset, start, stop, offset
// - decode stream on, stream off, read once
// - register read/write: address, then count byte
// - register read ignored while streaming
// - oscillator master drives clock pin when enabled
// - start opcode sets run flag but does not restart while converting
module adc_conversion_and_opcode_control
  import adc_ctrl_pkg::*;
#(
  // settle times in modulator periods, index is the rate code
  parameter logic [7:0][12:0] SETTLE_TABLE = {`SETTLE_R7, `SETTLE_R6, `SETTLE_R5, `SETTLE_R4,
                                              `SETTLE_R3, `SETTLE_R2, `SETTLE_R1, `SETTLE_R0}
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_pin_i,
  input  wire logic       cs_n_i,
  input  wire logic       sclk_i,
  input  wire logic       din_i,
  input  wire logic       result_bit_i,
  input  wire logic [2:0] rate_select_i,
  input  wire logic       clk_div_i,
  input  wire logic       single_shot_i,
  input  wire logic       osc_source_pin_i,
  input  wire logic       clk_out_en_i,
  output logic            data_ready_n_o,
  output logic            dout_o,
  output logic            dout_oe_o,
  output logic            clk_pin_o,
  output logic            clk_pin_oe_o,
  output logic            filter_reset_o,
  output logic            conv_active_o,
  output logic            stream_read_o,
  output sys_cmd_type     sys_cmd_o,
  output reg_cmd_type     reg_cmd_o,
  output logic            reg_cmd_valid_o
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  for (genvar g = 0; g < 8; g++) begin : g_chk
    if (SETTLE_TABLE[g] < `SETTLE_MIN || SETTLE_TABLE[g][1:0] != 2'h0) begin : g_bad
      $error("settle entry too small or not a multiple of four");
    end
  end

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  rx_event_type   evt;
  logic [1:0]     start_sync_reg, start_sync_next;
  logic [1:0]     osc_sync_reg, osc_sync_next;
  logic           start_d_reg, start_d_next;
  logic           dout_reg, dout_next;
  logic           oe_reg, oe_next;
  logic           clkp_reg, clkp_next;
  logic           clkp_oe_reg, clkp_oe_next;
  conv_state_type conv_reg, conv_next;
  logic [12:0]    cnt_reg, cnt_next;
  logic [4:0]     mod_reg, mod_next;
  logic           data_ready_n_reg, data_ready_n_next;
  logic           run_reg, run_next;
  logic           filt_reg, filt_next;
  logic           act_reg, act_next;
  cmd_state_type  cst_reg, cst_next;
  logic [1:0]     pend_reg, pend_next;
  logic [4:0]     addr_reg, addr_next;
  logic           stream_reg, stream_next;
  sys_cmd_type    sys_reg, sys_next;
  reg_cmd_type    regc_reg, regc_next;
  logic           regv_reg, regv_next;
  logic           start_cmd, stop_cmd, reset_cmd;
  logic           sys7, byte8;
  logic [4:0]     mod_last;
  logic           tick, run_req, pin_rise, busy, start_ok;
  logic [12:0]    settle_sel, period_sel;

  // ----------------------------------------
  // serial receiver
  // ----------------------------------------
  serial_byte_rx u_rx (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .cs_n_i    (cs_n_i),
    .sclk_i    (sclk_i),
    .din_i     (din_i),
    .evt_o     (evt)
  );

  // ----------------------------------------
  // pins: synchronisers, serial output, clock pin
  // ----------------------------------------
  always_comb begin
    start_sync_next = {start_sync_reg[0], start_pin_i};
    osc_sync_next   = {osc_sync_reg[0], osc_source_pin_i};
    start_d_next    = start_sync_reg[1];
    dout_next       = result_bit_i;
    oe_next         = ~evt.cs_high;
    clkp_oe_next    = osc_sync_reg[1] & clk_out_en_i;
    clkp_next       = clkp_oe_next & ~clkp_reg;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      start_sync_reg <= 2'h0;
      osc_sync_reg   <= 2'h0;
      start_d_reg    <= 1'b0;
      dout_reg       <= 1'b0;
      oe_reg         <= 1'b0;
      clkp_reg       <= 1'b0;
      clkp_oe_reg    <= 1'b0;
    end else begin
      start_sync_reg <= start_sync_next;
      osc_sync_reg   <= osc_sync_next;
      start_d_reg    <= start_d_next;
      dout_reg       <= dout_next;
      oe_reg         <= oe_next;
      clkp_reg       <= clkp_next;
      clkp_oe_reg    <= clkp_oe_next;
    end
  end

  // ----------------------------------------
  // command decoder
  // ----------------------------------------
  always_comb begin
    cst_next    = cst_reg;
    pend_next   = pend_reg;
    addr_next   = addr_reg;
    stream_next = stream_reg;
    sys_next    = '0;
    regc_next   = regc_reg;
    regv_next   = 1'b0;
    start_cmd   = 1'b0;
    stop_cmd    = 1'b0;
    reset_cmd   = 1'b0;
    sys7  = evt.fall && evt.bits == `BIT_SYS && cst_reg == CMD_FIRST;
    byte8 = evt.fall && evt.bits == `BIT_REG;
    // seventh edge: single-byte system opcodes
    if (sys7) begin
      unique case ({evt.shift[6:0], 1'b0})
        `OP_WAKE:      sys_next.wake = 1'b1;
        `OP_STANDBY:   sys_next.standby = 1'b1;
        `OP_RESET: begin
          sys_next.reset = 1'b1;
          reset_cmd      = 1'b1;
          stream_next    = 1'b1;
        end
        `OP_START:     start_cmd = 1'b1;
        `OP_STOP:      stop_cmd = 1'b1;
        `OP_OFFSET:    sys_next.offset = 1'b1;
        `OP_READ_ONCE: sys_next.read_once = 1'b1;
        default:       ;
      endcase
    end
    // eighth edge: stream mode and register opcodes
    if (byte8) begin
      if (cst_reg == CMD_FIRST) begin
        if (evt.shift == `OP_STREAM_ON) begin
          stream_next = 1'b1;
        end else if (evt.shift == `OP_STREAM_OFF) begin
          stream_next = 1'b0;
        end else if (evt.shift[7:5] == `OP_FETCH_HI || evt.shift[7:5] == `OP_STORE_HI) begin
          cst_next  = CMD_SECOND;
          addr_next = evt.shift[4:0];
          pend_next = {evt.shift[7:5] == `OP_STORE_HI,
                       evt.shift[7:5] == `OP_FETCH_HI && !stream_reg};
        end
      end else begin
        cst_next = CMD_FIRST;
        if (evt.shift[7:5] == `OP_COUNT_HI && pend_reg != 2'h0) begin
          regv_next = 1'b1;
          regc_next = '{store: pend_reg[1], addr: addr_reg, count: evt.shift[4:0]};
        end
      end
    end
    if (evt.cs_high) begin
      cst_next = CMD_FIRST;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cst_reg    <= CMD_FIRST;
      pend_reg   <= 2'h0;
      addr_reg   <= 5'h00;
      stream_reg <= 1'b1;   // streaming is the power-up mode
      sys_reg    <= '0;
      regc_reg   <= '0;
      regv_reg   <= 1'b0;
    end else begin
      cst_reg    <= cst_next;
      pend_reg   <= pend_next;
      addr_reg   <= addr_next;
      stream_reg <= stream_next;
      sys_reg    <= sys_next;
      regc_reg   <= regc_next;
      regv_reg   <= regv_next;
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  assign mod_last   = clk_div_i ? `MOD_LAST_DIV1 : `MOD_LAST_DIV0;
  assign settle_sel = SETTLE_TABLE[rate_select_i];
  assign period_sel = (settle_sel - `SETTLE_FIXED) >> `FILL_SHIFT;

  always_comb begin
    tick      = mod_reg >= mod_last;                     // recovers at once when the divide shrinks
    mod_next  = tick ? 5'h00 : mod_reg + 5'h01;
    conv_next = conv_reg;
    cnt_next  = cnt_reg;
    data_ready_n_next = data_ready_n_reg;
    run_next  = run_reg;
    filt_next = 1'b0;
    run_req   = start_sync_reg[1] | run_reg;
    pin_rise  = start_sync_reg[1] & ~start_d_reg;
    busy      = conv_reg == CONV_SETTLE || conv_reg == CONV_RUN;
    if (start_cmd) begin
      run_next = 1'b1;
    end
    if (stop_cmd) begin
      run_next = 1'b0;
    end
    // any serial clock fall while running clears the ready flag
    if (evt.fall && conv_reg == CONV_RUN) begin
      data_ready_n_next = 1'b1;
    end
    unique case (conv_reg)
      CONV_IDLE, CONV_HOLD: ;
      CONV_SETTLE, CONV_RUN: begin
        if (tick) begin
          cnt_next = cnt_reg - 13'h0001;
          if (conv_reg == CONV_RUN && cnt_reg == 13'h0002) begin
            data_ready_n_next = 1'b1;
          end
          if (cnt_reg == 13'h0001) begin
            data_ready_n_next = 1'b0;
            if (single_shot_i) begin
              conv_next = CONV_HOLD;
            end else if (!run_req) begin
              conv_next = CONV_IDLE;
            end else begin
              conv_next = CONV_RUN;
              cnt_next  = period_sel;
            end
          end
        end
      end
    endcase
    // pin rise restarts unless a reset opcode comes in the same cycle; opcode only when not converting
    start_ok = pin_rise | (start_cmd & ~busy);
    if (start_ok) begin
      conv_next = CONV_SETTLE;
      cnt_next  = settle_sel;
      mod_next  = 5'h00;
      data_ready_n_next = 1'b1;
      filt_next = 1'b1;
    end
    if (reset_cmd) begin
      conv_next = CONV_IDLE;
      run_next  = 1'b0;
      data_ready_n_next = 1'b1;
    end
    act_next = conv_next == CONV_SETTLE || conv_next == CONV_RUN;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      conv_reg <= CONV_IDLE;
      cnt_reg  <= 13'h0000;
      mod_reg  <= 5'h00;
      data_ready_n_reg <= 1'b1;
      run_reg  <= 1'b0;
      filt_reg <= 1'b0;
      act_reg  <= 1'b0;
    end else begin
      conv_reg <= conv_next;
      cnt_reg  <= cnt_next;
      mod_reg  <= mod_next;
      data_ready_n_reg <= data_ready_n_next;
      run_reg  <= run_next;
      filt_reg <= filt_next;
      act_reg  <= act_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign data_ready_n_o  = data_ready_n_reg;
  assign dout_o          = dout_reg;
  assign dout_oe_o       = oe_reg;
  assign clk_pin_o       = clkp_reg;
  assign clk_pin_oe_o    = clkp_oe_reg;
  assign filter_reset_o  = filt_reg;
  assign conv_active_o   = act_reg;
  assign stream_read_o   = stream_reg;
  assign sys_cmd_o       = sys_reg;
  assign reg_cmd_o       = regc_reg;
  assign reg_cmd_valid_o = regv_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // cycles since the last accepted start
  logic [17:0] since_reg;
  logic [17:0] target_cyc;
  assign target_cyc = 18'(settle_sel) * 18'({1'b0, mod_last} + 6'h01) + 18'h0_0001;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      since_reg <= 18'h0_0000;
    end else begin
      since_reg <= start_ok ? 18'h0_0001 : since_reg + 18'h0_0001;
    end
  end

  data_ready_n_on_start_a: assert property (start_ok |=> data_ready_n_o && conv_reg == CONV_SETTLE)
    else $error("data-ready not raised on start");
  settle_delay_a: assert property ($fell(data_ready_n_o) && $past(conv_reg) == CONV_SETTLE
    |-> since_reg == target_cyc)
    else $error("first data not at settle time");
  mod_spacing_a: assert property (tick && !clk_div_i |=> !tick [*3])
    else $error("modulator tick too early");
  one_shot_stop_a: assert property ($fell(data_ready_n_o) && $past(single_shot_i)
    |-> conv_reg == CONV_HOLD)
    else $error("one-shot did not stop");
  hold_low_a: assert property (conv_reg == CONV_HOLD |-> !data_ready_n_o)
    else $error("data-ready rose in one-shot hold");
  stop_finish_a: assert property (conv_reg == CONV_RUN && !run_req && !tick && !reset_cmd
    |=> conv_reg == CONV_RUN)
    else $error("conversion cut short on halt");
  busy_start_a: assert property (start_cmd && !pin_rise && conv_reg == CONV_RUN
    |=> !filter_reset_o && conv_reg != CONV_SETTLE)
    else $error("start acted while converting");
  filter_reset_a: assert property (start_ok |=> filter_reset_o)
    else $error("filter not reset on start");
  start_decode_a: assert property (sys7 && {evt.shift[6:0], 1'b0} == `OP_START
    && !busy |=> conv_reg == CONV_SETTLE)
    else $error("start opcode not taken at seventh edge");
  release_out_a: assert property (evt.cs_high |=> !dout_oe_o)
    else $error("serial output driven while deselected");
  fetch_gate_a: assert property (byte8 && cst_reg == CMD_FIRST && stream_reg
    && evt.shift[7:5] == `OP_FETCH_HI |=> pend_reg == 2'h0)
    else $error("register read accepted while streaming");
  stream_off_a: assert property (byte8 && cst_reg == CMD_FIRST
    && evt.shift == `OP_STREAM_OFF |=> !stream_read_o)
    else $error("stream mode not left");
  clk_toggle_a: assert property (clk_pin_oe_o && $past(clk_pin_oe_o)
    |-> clk_pin_o != $past(clk_pin_o))
    else $error("clock pin not toggling");

endmodule : adc_conversion_and_opcode_control

`default_nettype wire

/* File: verification/host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module host_model (
  input  wire logic clk_sys_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      din_o
);
  // ----------------------------------------
  // serial master, clock idles low between frames
  // ----------------------------------------
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o  = 1'b0;
  end

  // one byte msb first, data changes on rise, device takes it on fall
  task automatic send_byte(input logic [7:0] b, input logic last);
    cs_n_o <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      din_o  <= b[i];
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b0;
    end
    repeat (8) @(posedge clk_sys_i); // decode gap between bytes
    if (last) begin
      cs_n_o <= 1'b1;
      din_o  <= ~din_o; // no stale bit left on the line
      repeat (8) @(posedge clk_sys_i);
    end
  endtask : send_byte
endmodule : host_model

`default_nettype wire

/* File: verification/adc_conversion_and_opcode_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module adc_conversion_and_opcode_control_tb;
  import adc_ctrl_pkg::*;
  localparam logic [7:0][12:0] SETTLE_TB = {13'h0040, 13'h003C, 13'h0038, 13'h0034,
                                            13'h0030, 13'h002C, 13'h0028, 13'h0024};
  localparam logic [7:0] OPS [5] = '{8'h02, 8'h04, 8'h06, 8'h1A, 8'h12};
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, start_pin_i = 1'b0, result_bit_i = 1'b0;
  logic [2:0] rate_select_i = 3'h0;
  logic clk_div_i = 1'b0, single_shot_i = 1'b1, osc_source_pin_i = 1'b0, clk_out_en_i = 1'b0;
  logic cs_n, sclk, din, data_ready_n_o, dout_o, dout_oe_o, clk_pin_o, clk_pin_oe_o;
  logic filter_reset_o, conv_active_o, stream_read_o, reg_cmd_valid_o, dr_q = 1'b1, rb_q = 1'b0;
  sys_cmd_type sys_cmd_o;
  reg_cmd_type reg_cmd_o;
  sys_cmd_type sys_q[$];
  reg_cmd_type reg_q[$];
  logic [31:0] lfsr = 32'h0000_43e4;
  int cyc = 0, falls = 0, resets = 0, last_fall = 0, prev_fall = 0, cs_hi = 0;
  int mismatches = 0, checked = 0, per, n, t0, r0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  host_model host (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));

  adc_conversion_and_opcode_control #(.SETTLE_TABLE(SETTLE_TB)) uut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_pin_i(start_pin_i), .cs_n_i(cs_n),
    .sclk_i(sclk), .din_i(din), .result_bit_i(result_bit_i), .rate_select_i(rate_select_i),
    .clk_div_i(clk_div_i), .single_shot_i(single_shot_i), .osc_source_pin_i(osc_source_pin_i),
    .clk_out_en_i(clk_out_en_i), .data_ready_n_o(data_ready_n_o), .dout_o(dout_o),
    .dout_oe_o(dout_oe_o), .clk_pin_o(clk_pin_o), .clk_pin_oe_o(clk_pin_oe_o),
    .filter_reset_o(filter_reset_o), .conv_active_o(conv_active_o), .stream_read_o(stream_read_o),
    .sys_cmd_o(sys_cmd_o), .reg_cmd_o(reg_cmd_o), .reg_cmd_valid_o(reg_cmd_valid_o));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wait_fall(input int limit);
    int f0;
    f0 = falls;
    for (int i = 0; i < limit && falls == f0; i++) @(posedge clk_sys_i);
    check(falls != f0, 1'b1, "no data ready fall");
  endtask : wait_fall

  // single conversion from a start pin pulse
  task automatic one_shot(input logic [2:0] code, input logic div);
    per = SETTLE_TB[code] * (div ? 16 : 4);
    r0  = resets;
    @(posedge clk_sys_i);
    rate_select_i <= code;
    clk_div_i     <= div;
    start_pin_i   <= 1'b1;
    t0 = cyc;
    repeat (20) @(posedge clk_sys_i); // wider than one modulator period
    check(data_ready_n_o, 1'b1, "ready not raised");
    start_pin_i <= 1'b0; // low again before next rise
    wait_fall(per + 40);
    check(last_fall - t0 >= per && last_fall - t0 <= per + 24, 1'b1, "settle time");
    check(resets - r0, 1, "filter reset count");
    repeat (200) @(posedge clk_sys_i);
    check(data_ready_n_o, 1'b0, "ready not held low");
    check(conv_active_o, 1'b0, "still converting");
  endtask : one_shot

  // cycle count, random data, edge tracking, watchdog
  always @(posedge clk_sys_i) begin
    cyc          <= cyc + 1;
    lfsr         <= lfsr_next(lfsr);
    result_bit_i <= lfsr[0];
    dr_q         <= data_ready_n_o;
    rb_q         <= result_bit_i;
    cs_hi        <= cs_n ? cs_hi + 1 : 0;
    if (filter_reset_o === 1'b1) resets <= resets + 1;
    if (dr_q === 1'b1 && data_ready_n_o === 1'b0) begin
      falls     <= falls + 1;
      prev_fall <= last_fall;
      last_fall <= cyc;
    end
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // output monitor, pops the oldest expected command on each pulse
  always @(negedge clk_sys_i) begin
    if (cs_hi > 4) check(dout_oe_o, 1'b0, "output driven while deselected");
    if (cyc > 20) check(dout_o, rb_q, "serial output data");
    if (sys_cmd_o !== 5'h00) begin
      if (sys_q.size() == 0) check(sys_cmd_o, 5'h00, "unexpected command pulse");
      else check(sys_cmd_o, sys_q.pop_front(), "command pulse");
    end
    if (reg_cmd_valid_o !== 1'b0) begin
      if (reg_q.size() == 0) check(reg_cmd_valid_o, 1'b0, "unexpected register command");
      else check(reg_cmd_o, reg_q.pop_front(), "register command");
    end
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    check(data_ready_n_o, 1'b1, "ready after reset");
    check(stream_read_o, 1'b1, "stream default");
    for (int d = 0; d < 2; d++) for (int c = 0; c < 8; c++) one_shot(c[2:0], d[0]);
    single_shot_i <= 1'b0;
    rate_select_i <= 3'h7;
    clk_div_i     <= 1'b0;
    per = SETTLE_TB[7] - 4;
    host.send_byte(8'h0A, 1'b1); // stop then start on mode change
    host.send_byte(8'h08, 1'b1); // start acts at seventh fall
    wait_fall(400);
    wait_fall(100);
    check(last_fall - prev_fall, per, "running period");
    repeat (4) @(posedge clk_sys_i); // one extra modulator period before clocking
    host.send_byte(8'h08, 1'b1);
    wait_fall(100);
    check(last_fall - prev_fall, per, "start while running");
    host.send_byte(8'h0A, 1'b1);
    repeat (150) @(posedge clk_sys_i);
    n = falls;
    repeat (300) @(posedge clk_sys_i);
    check(falls - n, 0, "stop opcode");
    check(conv_active_o, 1'b0, "active after stop");
    start_pin_i <= 1'b1;
    wait_fall(400);
    start_pin_i <= 1'b0; // well over eight periods before next fall
    n = falls;
    repeat (300) @(posedge clk_sys_i);
    check(falls - n, 1, "conversion in progress completes");
    for (int i = 0; i < 5; i++) begin
      sys_q.push_back(sys_cmd_type'(5'h10 >> i));
      host.send_byte(OPS[i], 1'b1);
    end
    host.send_byte(8'h11, 1'b1);
    check(stream_read_o, 1'b0, "stream off");
    reg_q.push_back(reg_cmd_type'({1'b0, 5'h03, 5'h01}));
    host.send_byte(8'h23, 1'b0);
    host.send_byte(8'h01, 1'b1);
    reg_q.push_back(reg_cmd_type'({1'b1, 5'h05, 5'h1F}));
    host.send_byte(8'h45, 1'b0);
    host.send_byte(8'h1F, 1'b1);
    host.send_byte(8'hFF, 1'b1);
    host.send_byte(8'h10, 1'b1);
    check(stream_read_o, 1'b1, "stream on");
    host.send_byte(8'h23, 1'b0);
    host.send_byte(8'h01, 1'b1);
    check(sys_q.size() + reg_q.size(), 0, "commands not seen");
    for (int v = 0; v < 4; v++) begin
      osc_source_pin_i <= v[1];
      clk_out_en_i     <= v[0];
      repeat (6) @(posedge clk_sys_i);
      check(clk_pin_oe_o, v == 3, "clock pin enable");
      n = clk_pin_o;
      @(posedge clk_sys_i);
      if (v == 3) check(clk_pin_o, !n[0], "clock pin toggle");
    end
    tally_and_finish();
  end
endmodule : adc_conversion_and_opcode_control_tb

`default_nettype wire
